// [fcl_regs.svh]
`ifndef FCL_REGS_SVH
`define FCL_REGS_SVH
// Register indices; byte address is four times the index.
`define FCL_IDX_BOD     4'h1
`define FCL_IDX_OSC     4'h2
`define FCL_IDX_SYS0    4'h5
`define FCL_IDX_SYS1    4'h6
`define FCL_IDX_CODE    4'h7
`define FCL_IDX_BOOT    4'h8
`define FCL_IDX_LOCK    4'hA
`define FCL_IDX_STATUS  4'hB
// Reset values of the fuse shadows.
`define FCL_RST_BOD     8'h00
`define FCL_RST_OSC     8'h02
`define FCL_RST_SYS0    8'hC4
`define FCL_RST_SYS1    8'h07
`define FCL_RST_CODE    8'h00
`define FCL_RST_BOOT    8'h00
`define FCL_RST_LOCK    8'h00
// Field positions.
`define FCL_BOD_LVL     7:5
`define FCL_BOD_RATE    4
`define FCL_BOD_ACT     3:2
`define FCL_BOD_SLP     1:0
`define FCL_OSC_LOCK    7
`define FCL_OSC_FREQ    1:0
`define FCL_SYS0_SCAN   7:6
`define FCL_SYS0_PIN    3:2
`define FCL_SYS0_EE     0
`define FCL_SYS1_SUT    2:0
// Codes and constants.
`define FCL_OPEN_KEY    8'hC5
`define FCL_FREQ_16     2'h1
`define FCL_FREQ_20     2'h2
`define FCL_SCAN_NONE   2'h3
`define FCL_PIN_RSVD    2'h3
`define FCL_SLP_RSVD    2'h3
`define FCL_BLOCK_BYTES 256
`define FCL_CLK_HZ      20000000
`define FCL_SUT_UNIT_MS 1
`define FCL_FUSE_STEPS  7
`endif

// [fcl_pkg.sv]
package fcl_pkg;
   typedef enum logic [1:0] {
      FCL_BOOT     = 2'h0,
      FCL_APP_CODE = 2'h1,
      FCL_APP_DATA = 2'h2
   } fcl_region_e;
   typedef enum logic [1:0] {
      FCL_ADDR = 2'h0,
      FCL_CAPT = 2'h1,
      FCL_DONE = 2'h3
   } fcl_walk_e;
   typedef logic [3:0] fcl_index_t;
endpackage

// [fcl_walk_if.sv]
`timescale 1ns/100ps
interface fcl_walk_if;
   logic [3:0] fuse_index;
   logic       capture;
   logic       done;
   modport walker (output fuse_index, output capture, output done);
   modport core   (input fuse_index, input capture, input done);
endinterface

// [fcl_fuse_walker.sv]
`timescale 1ns/100ps
`include "fcl_regs.svh"
module fcl_fuse_walker (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Walk towards the loader core.
   fcl_walk_if.walker walk
);
   import fcl_pkg::*;

   fcl_walk_e  state_q;
   logic [2:0] step_q;

   function automatic fcl_index_t step_index(input logic [2:0] s);
      case (s)
         3'h0:    step_index = `FCL_IDX_BOD;
         3'h1:    step_index = `FCL_IDX_OSC;
         3'h2:    step_index = `FCL_IDX_SYS0;
         3'h3:    step_index = `FCL_IDX_SYS1;
         3'h4:    step_index = `FCL_IDX_CODE;
         3'h5:    step_index = `FCL_IDX_BOOT;
         default: step_index = `FCL_IDX_LOCK;
      endcase
   endfunction

   // The fuse array answers one cycle after the index is presented.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= FCL_ADDR;
         step_q  <= 3'h0;
      end else begin
         unique case (state_q)
            FCL_ADDR: state_q <= FCL_CAPT;
            FCL_CAPT: begin
               if (step_q == 3'(`FCL_FUSE_STEPS - 1)) begin
                  state_q <= FCL_DONE;
               end else begin
                  state_q <= FCL_ADDR;
                  step_q  <= step_q + 3'h1;
               end
            end
            FCL_DONE: state_q <= FCL_DONE;
            default:  state_q <= FCL_ADDR;
         endcase
      end
   end

   assign walk.fuse_index = step_index(step_q);
   assign walk.capture    = (state_q == FCL_CAPT);
   assign walk.done       = (state_q == FCL_DONE);
endmodule // fcl_fuse_walker

// [fcl_fuse_config_loader.sv]
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "fcl_regs.svh"
// Overview of operation
// R1: Brown-out fields reload only on power-on reset.
// R2: Fuse bits 7:5 give brown-out threshold.
// R3: Fuse bit 4 gives brown-out sample rate.
// R4: Fuse bits 3:2 give active brown-out mode.
// R5: Fuse bits 1:0 give sleep brown-out mode.
// R6: Oscillator bit 7 locks calibration registers.
// R7: Frequency select picks clock and trims.
// R8: Bits 7:6 choose memory scan region.
// R9: Bits 3:2 choose shared pin function.
// R10: Preserve EEPROM unless device is locked.
// R11: Bits 2:0 set power-on start-up delay.
// R12: Code limit ends code section, zero means all.
// R13: Boot limit ends boot section, zero all.
// R14: Both limits zero means whole flash boot.
// R15: Flash beyond code limit is data.
// R16: Software sets code limit boot plus code.
// R17: Only key C5 leaves device open.
// R18: Load all fuses before release; read-only. The key register still takes software writes.
// R19: Reserved codes are flagged, not acted on.
module fcl_fuse_config_loader #(
   parameter int ADDR_W      = 8,
   parameter int FLASH_BYTES = 16384,
   parameter int UNIT_CYCLES =
      `FCL_SUT_UNIT_MS * (`FCL_CLK_HZ / 1000)
) (
   // Clock, reset and reset cause.
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              por_flag,
   // Fuse array read port.
   output      fcl_pkg::fcl_index_t fuse_index,
   input  wire logic [7:0]        fuse_data,
   // Factory trims for both frequencies.
   input  wire logic [7:0]        cal16_freq_trim,
   input  wire logic [3:0]        cal16_temp_trim,
   input  wire logic [7:0]        cal20_freq_trim,
   input  wire logic [3:0]        cal20_temp_trim,
   // Brown-out detector settings.
   output      logic [2:0]        brownout_threshold,
   output      logic              brownout_sample_rate,
   output      logic [1:0]        brownout_active_mode,
   output      logic [1:0]        brownout_sleep_mode,
   output      logic              brownout_sleep_valid,
   // Oscillator settings.
   output      logic              calibration_lock,
   output      logic [1:0]        oscillator_freq_select,
   output      logic              oscillator_freq_valid,
   output      logic [7:0]        frequency_trim,
   output      logic [3:0]        temperature_trim,
   // System settings.
   output      logic [1:0]        scan_region_select,
   output      logic              scan_enable,
   output      logic [1:0]        shared_pin_function,
   output      logic              shared_pin_valid,
   output      logic              eeprom_preserve,
   output      logic [2:0]        startup_delay,
   output      logic              device_locked,
   output      logic              debug_bus_grant,
   output      logic              cpu_release,
   // Flash section query.
   input  wire logic [16:0]       flash_addr,
   output      fcl_pkg::fcl_region_e flash_region,
   output      logic [16:0]       boot_section_end,
   output      logic [16:0]       code_section_end,
   // AXI4-Lite slave.
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   import fcl_pkg::*;

   localparam logic [16:0] FLASH_END = 17'(FLASH_BYTES);

   fcl_walk_if walk ();

   fcl_fuse_walker u_walker (
      .aclk    (aclk),
      .aresetn (aresetn),
      .walk    (walk.walker)
   );

   assign fuse_index = walk.fuse_index;

   // Reset cause crosses in from the reset controller.
   logic por_s1_q;
   logic por_s2_q;
   logic por_q;
   logic [1:0] rst_age_q;

   always_ff @(posedge aclk) begin
      por_s1_q <= por_flag;
      por_s2_q <= por_s1_q;
   end

   // For two edges after reset falls the synchroniser still holds the
   // cause of the previous reset, so it is not trusted until then.
   always_ff @(posedge aclk) begin
      rst_age_q <= {rst_age_q[0], !aresetn};
   end

   // The cause is caught while reset is held, then frozen.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_q <= por_s2_q;
      end
   end

   // Fuse shadows.
   logic [7:0] bod_q, osc_q, sys0_q, sys1_q;
   logic [7:0] code_q, boot_q, lock_q;
   logic       cap;
   logic       sw_lock_wr;
   logic [7:0] sw_lock_data;

   assign cap = walk.capture;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bod_q  <= `FCL_RST_BOD;
         osc_q  <= `FCL_RST_OSC;
         sys0_q <= `FCL_RST_SYS0;
         sys1_q <= `FCL_RST_SYS1;
         code_q <= `FCL_RST_CODE;
         boot_q <= `FCL_RST_BOOT;
      end else if (cap) begin
         unique case (walk.fuse_index)
            `FCL_IDX_BOD:  bod_q  <= fuse_data;
            `FCL_IDX_OSC:  osc_q  <= fuse_data;
            `FCL_IDX_SYS0: sys0_q <= fuse_data;
            `FCL_IDX_SYS1: sys1_q <= fuse_data;
            `FCL_IDX_CODE: code_q <= fuse_data;
            `FCL_IDX_BOOT: boot_q <= fuse_data;
            default: ;
         endcase
      end
   end

   // The loaded key wins over a software write in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= `FCL_RST_LOCK;
      end else if (cap && walk.fuse_index == `FCL_IDX_LOCK) begin
         lock_q <= fuse_data;
      end else if (sw_lock_wr) begin
         lock_q <= sw_lock_data;
      end
   end

   // Brown-out settings survive every reset except power-on.
   always_ff @(posedge aclk) begin
      if (!aresetn && rst_age_q[1] && por_s2_q) begin // [R1]
         brownout_threshold   <= 3'h0;
         brownout_sample_rate <= 1'b0;
         brownout_active_mode <= 2'h0;
         brownout_sleep_mode  <= 2'h0;
      end else if (aresetn && por_q && cap &&
                   walk.fuse_index == `FCL_IDX_BOD) begin // [R1]
         brownout_threshold   <= fuse_data[`FCL_BOD_LVL]; // [R2]
         brownout_sample_rate <= fuse_data[`FCL_BOD_RATE]; // [R3]
         brownout_active_mode <= fuse_data[`FCL_BOD_ACT]; // [R4]
         brownout_sleep_mode  <= fuse_data[`FCL_BOD_SLP]; // [R5]
      end
   end

   // Reserved sleep code passes through but is flagged invalid.
   assign brownout_sleep_valid =
      (brownout_sleep_mode != `FCL_SLP_RSVD); // [R5] [R19]

   // Trims follow the frequency code; a reserved code keeps them.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frequency_trim   <= 8'h00;
         temperature_trim <= 4'h0;
      end else if (cap && walk.fuse_index == `FCL_IDX_OSC) begin
         if (fuse_data[`FCL_OSC_FREQ] == `FCL_FREQ_16) begin // [R7]
            frequency_trim   <= cal16_freq_trim;
            temperature_trim <= cal16_temp_trim;
         end else if (fuse_data[`FCL_OSC_FREQ] == `FCL_FREQ_20) begin
            frequency_trim   <= cal20_freq_trim; // [R7]
            temperature_trim <= cal20_temp_trim;
         end
      end
   end

   assign calibration_lock       = osc_q[`FCL_OSC_LOCK]; // [R6]
   assign oscillator_freq_select = osc_q[`FCL_OSC_FREQ]; // [R7]
   assign oscillator_freq_valid  =
      (osc_q[`FCL_OSC_FREQ] == `FCL_FREQ_16) ||
      (osc_q[`FCL_OSC_FREQ] == `FCL_FREQ_20); // [R19]

   assign scan_region_select = sys0_q[`FCL_SYS0_SCAN]; // [R8]
   assign scan_enable = (sys0_q[`FCL_SYS0_SCAN] != `FCL_SCAN_NONE);
   assign shared_pin_function = sys0_q[`FCL_SYS0_PIN]; // [R9]
   assign shared_pin_valid =
      (sys0_q[`FCL_SYS0_PIN] != `FCL_PIN_RSVD); // [R19]
   assign startup_delay = sys1_q[`FCL_SYS1_SUT]; // [R11]

   assign device_locked   = (lock_q != `FCL_OPEN_KEY); // [R17]
   // Locked devices keep the debug port off the system bus.
   assign debug_bus_grant = !device_locked; // [R17]
   assign eeprom_preserve =
      sys0_q[`FCL_SYS0_EE] && !device_locked; // [R10]

   // Flash sections; a zero limit stretches to the end of flash.
   function automatic logic [16:0] limit_end(input logic [7:0] v);
      if (v == 8'h00) begin
         limit_end = FLASH_END;
      end else begin
         limit_end = 17'(v) * 17'(`FCL_BLOCK_BYTES);
      end
   endfunction

   assign boot_section_end = limit_end(boot_q); // [R13]
   assign code_section_end = limit_end(code_q); // [R12]

   always_comb begin
      if (flash_addr < boot_section_end) begin // [R14]
         flash_region = FCL_BOOT;
      end else if (flash_addr < code_section_end) begin
         flash_region = FCL_APP_CODE;
      end else begin
         flash_region = FCL_APP_DATA; // [R15]
      end
   end

   // Start-up delay runs after the load, and only after power-on.
   logic [23:0] delay_cnt_q;
   logic [23:0] delay_target;

   assign delay_target = (startup_delay == 3'h0) ? 24'h000000 :
      24'(UNIT_CYCLES) << (startup_delay - 3'h1); // [R11]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         delay_cnt_q <= 24'h000000;
         cpu_release <= 1'b0;
      end else if (walk.done && !cpu_release) begin // [R18]
         if (!por_q || delay_cnt_q >= delay_target) begin
            cpu_release <= 1'b1;
         end else begin
            delay_cnt_q <= delay_cnt_q + 24'h000001;
         end
      end
   end

   // AXI4-Lite register access.
   function automatic logic reg_known(input fcl_index_t i);
      reg_known = (i == `FCL_IDX_BOD)  || (i == `FCL_IDX_OSC)  ||
                  (i == `FCL_IDX_SYS0) || (i == `FCL_IDX_SYS1) ||
                  (i == `FCL_IDX_CODE) || (i == `FCL_IDX_BOOT) ||
                  (i == `FCL_IDX_LOCK) || (i == `FCL_IDX_STATUS);
   endfunction

   function automatic fcl_index_t word_index(
      input logic [ADDR_W-1:0] a);
      if (a[ADDR_W-1:6] != '0) begin
         word_index = 4'hF;
      end else begin
         word_index = a[5:2];
      end
   endfunction

   logic [7:0] read_byte;
   fcl_index_t rd_idx;

   assign rd_idx = word_index(s_axi_araddr);

   always_comb begin
      unique case (rd_idx)
         `FCL_IDX_BOD:    read_byte = bod_q;
         `FCL_IDX_OSC:    read_byte = osc_q;
         `FCL_IDX_SYS0:   read_byte = sys0_q;
         `FCL_IDX_SYS1:   read_byte = sys1_q;
         `FCL_IDX_CODE:   read_byte = code_q;
         `FCL_IDX_BOOT:   read_byte = boot_q;
         `FCL_IDX_LOCK:   read_byte = lock_q;
         `FCL_IDX_STATUS: read_byte = {5'h00, device_locked,
                                       por_q, walk.done};
         default:         read_byte = 8'h00;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, read_byte};
         s_axi_rresp  <= reg_known(rd_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   logic              aw_held_q, w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wbyte_q;
   logic              wlane_q;
   fcl_index_t        wr_idx;
   logic              commit;

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_idx        = word_index(awaddr_q);
   assign commit        = aw_held_q && w_held_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (commit) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wbyte_q  <= 8'h00;
         wlane_q  <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wbyte_q  <= s_axi_wdata[7:0];
         wlane_q  <= s_axi_wstrb[0];
      end else if (commit) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= reg_known(wr_idx) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the key is writable; other fuse bytes ignore writes.
   assign sw_lock_wr   = commit && wlane_q &&
                         (wr_idx == `FCL_IDX_LOCK); // [R18]
   assign sw_lock_data = wbyte_q;

   // Checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_bod_hold;
      !por_q |=> $stable(brownout_threshold) &&
                 $stable(brownout_active_mode);
   endproperty
   a_bod_hold: assert property (p_bod_hold) // [R1]
      else $error("brown-out changed without power-on");

   property p_bod_level;
      por_q && cap && walk.fuse_index == `FCL_IDX_BOD |=>
         brownout_threshold == $past(fuse_data[7:5]);
   endproperty
   a_bod_level: assert property (p_bod_level) // [R2]
      else $error("threshold not taken from fuse");

   property p_bod_rate;
      por_q && cap && walk.fuse_index == `FCL_IDX_BOD |=>
         brownout_sample_rate == $past(fuse_data[4]);
   endproperty
   a_bod_rate: assert property (p_bod_rate) // [R3]
      else $error("sample rate not taken from fuse");

   property p_bod_modes;
      por_q && cap && walk.fuse_index == `FCL_IDX_BOD |=>
         {brownout_active_mode, brownout_sleep_mode} ==
         $past(fuse_data[3:0]);
   endproperty
   a_bod_modes: assert property (p_bod_modes) // [R4] [R5]
      else $error("brown-out modes not taken from fuse");

   property p_trim20;
      cap && walk.fuse_index == `FCL_IDX_OSC &&
      fuse_data[1:0] == 2'h2 |=>
         frequency_trim == $past(cal20_freq_trim);
   endproperty
   a_trim20: assert property (p_trim20) // [R7]
      else $error("20 MHz trim not selected");

   property p_eeprom;
      eeprom_preserve |-> lock_q == 8'hC5 && sys0_q[0];
   endproperty
   a_eeprom: assert property (p_eeprom) // [R10]
      else $error("EEPROM preserved while locked");

   property p_debug;
      debug_bus_grant == (lock_q == 8'hC5);
   endproperty
   a_debug: assert property (p_debug) // [R17]
      else $error("debug grant disagrees with key");

   property p_release;
      cpu_release |-> walk.done;
   endproperty
   a_release: assert property (p_release) // [R18]
      else $error("released before fuses loaded");

   property p_fast_release;
      $rose(walk.done) && !por_q |=> cpu_release;
   endproperty
   a_fast_release: assert property (p_fast_release) // [R11]
      else $error("no-delay release late");

   property p_all_boot;
      code_q == 8'h00 && boot_q == 8'h00 |->
         flash_region == FCL_BOOT;
   endproperty
   a_all_boot: assert property (p_all_boot) // [R14]
      else $error("flash not all boot with zero limits");

   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold)
      else $error("read answer dropped early");

   c_release: cover property ($rose(cpu_release));
   c_locked: cover property (walk.done && device_locked);
   c_key_write: cover property (sw_lock_wr);
   c_data_region: cover property (flash_region == FCL_APP_DATA);
endmodule // fcl_fuse_config_loader

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import fcl_pkg::*;
`define CHECK(what, exp, got) begin total_checks++; \
if ((got) !== (exp)) begin n_fail++; \
$display("unexpected %s exp %0h got %0h", what, exp, got); end end
   // Behavioural fuse array; the data lags the index by one clock.
   logic [7:0]  fuse_mem [0:15];
   logic        aclk, aresetn, por_flag;
   fcl_index_t  fuse_index;
   logic [7:0]  fuse_data, s_axi_awaddr, s_axi_araddr, frequency_trim;
   logic [3:0]  s_axi_wstrb, temperature_trim;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs, brownout_active_mode;
   logic [1:0]  brownout_sleep_mode, oscillator_freq_select;
   logic [1:0]  scan_region_select, shared_pin_function;
   logic [2:0]  brownout_threshold, startup_delay;
   logic [16:0] flash_addr, boot_section_end, code_section_end;
   fcl_region_e flash_region;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, brownout_sample_rate;
   logic        brownout_sleep_valid, calibration_lock, scan_enable;
   logic        oscillator_freq_valid, shared_pin_valid, eeprom_preserve;
   logic        device_locked, debug_bus_grant, cpu_release;
   int          n_fail = 0, total_checks = 0, wait_n;
   logic [7:0]  idx [7] = '{8'h1, 8'h2, 8'h5, 8'h6, 8'h7, 8'h8, 8'hA};

   fcl_fuse_config_loader #(.UNIT_CYCLES(4)) u_fcl_fuse_config_loader (
      .aclk, .aresetn, .por_flag, .fuse_index, .fuse_data,
      .cal16_freq_trim(8'h5A), .cal16_temp_trim(4'h3),
      .cal20_freq_trim(8'hA5), .cal20_temp_trim(4'hC),
      .brownout_threshold, .brownout_sample_rate, .brownout_active_mode,
      .brownout_sleep_mode, .brownout_sleep_valid, .calibration_lock,
      .oscillator_freq_select, .oscillator_freq_valid, .frequency_trim,
      .temperature_trim, .scan_region_select, .scan_enable,
      .shared_pin_function, .shared_pin_valid, .eeprom_preserve,
      .startup_delay, .device_locked, .debug_bus_grant, .cpu_release,
      .flash_addr, .flash_region, .boot_section_end, .code_section_end,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   always #25 aclk = ~aclk;

   always @(posedge aclk) begin
      fuse_data <= fuse_mem[fuse_index];
   end

   task automatic load(input logic [7:0] b, o, s0, s1, c, bt, k);
      fuse_mem[1] = b;
      fuse_mem[2] = o;
      fuse_mem[5] = s0;
      fuse_mem[6] = s1;
      fuse_mem[7] = c;
      fuse_mem[8] = bt;
      fuse_mem[10] = k;
   endtask

   // The cause must stay put for the whole reset so it is synchronised.
   task automatic do_reset(input logic por);
      por_flag <= por;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      wait_n = 0;
      do begin
         @(negedge aclk);
         wait_n++;
      end while (cpu_release !== 1'b1 && wait_n < 2000);
      `CHECK("release", 1'b1, cpu_release)
   endtask

   // Ready is sampled at the falling edge; nothing changes until the
   // next rising edge, so it equals what the handshake edge sees.
   task automatic axi_read(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] st);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(negedge aclk);
         if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
         if (s_axi_wvalid && s_axi_wready) w = 1'b1;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1) @(negedge aclk);
      `CHECK("bresp", 2'b00, s_axi_bresp)
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic [1:0] r);
      axi_read(a);
      `CHECK("rdata", e, rd)
      `CHECK("rresp", r, rs)
   endtask

   task automatic chk_bod(input logic [2:0] t, input logic r,
                          input logic [1:0] a, s, input logic v);
      `CHECK("bod", {t, r, a, s, v}, {brownout_threshold,
         brownout_sample_rate, brownout_active_mode, brownout_sleep_mode,
         brownout_sleep_valid})
   endtask

   task automatic chk_osc(input logic lk, input logic [1:0] fs,
                          input logic fv, input logic [7:0] ft,
                          input logic [3:0] tt);
      `CHECK("osc", {lk, fs, fv, ft, tt}, {calibration_lock,
         oscillator_freq_select, oscillator_freq_valid, frequency_trim,
         temperature_trim})
   endtask

   task automatic chk_sys(input logic [1:0] sc, input logic se,
                          input logic [1:0] pf, input logic pv, ee,
                          input logic [2:0] sd, input logic lk);
      `CHECK("sys", {sc, se, pf, pv, ee, sd, lk, ~lk}, {scan_region_select,
         scan_enable, shared_pin_function, shared_pin_valid,
         eeprom_preserve, startup_delay, device_locked, debug_bus_grant})
   endtask

   task automatic chk_sec(input logic [16:0] be, ce);
      `CHECK("ends", {be, ce}, {boot_section_end, code_section_end})
   endtask

   task automatic reg_chk(input logic [16:0] a, input fcl_region_e e);
      @(posedge aclk);
      flash_addr <= a;
      @(negedge aclk);
      `CHECK("region", e, flash_region)
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Three loads with a long start-up delay plus bus traffic fit well
   // inside this span.
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      por_flag = 1'b1;
      fuse_data = 8'h00;
      flash_addr = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      foreach (fuse_mem[i]) fuse_mem[i] = 8'h3C;
      load(8'hB6, 8'h81, 8'h49, 8'h03, 8'h20, 8'h08, 8'hC5);
      do_reset(1'b1);
      `CHECK("delay", 1'b1, wait_n >= 30)
      chk_bod(3'h5, 1'b1, 2'h1, 2'h2, 1'b1);
      chk_osc(1'b1, 2'h1, 1'b1, 8'h5A, 4'h3);
      chk_sys(2'h1, 1'b1, 2'h2, 1'b1, 1'b1, 3'h3, 1'b0);
      chk_sec(17'h00800, 17'h02000);
      reg_chk(17'h007FF, FCL_BOOT);
      reg_chk(17'h00800, FCL_APP_CODE);
      reg_chk(17'h01FFF, FCL_APP_CODE);
      reg_chk(17'h02000, FCL_APP_DATA);
      foreach (idx[i])
         rd_chk(idx[i] << 2, {24'h0, fuse_mem[idx[i]]}, 2'b00);
      axi_write(8'h04, 32'h0000_00FF, 4'hF);
      rd_chk(8'h04, 32'h0000_00B6, 2'b00);
      axi_write(8'h28, 32'h0000_0000, 4'hF);
      `CHECK("locked", 2'b10, {device_locked, eeprom_preserve})
      axi_write(8'h28, 32'h0000_00C5, 4'hE);
      `CHECK("locked", 2'b10, {device_locked, eeprom_preserve})
      axi_write(8'h28, 32'h0000_00C5, 4'hF);
      `CHECK("locked", 2'b01, {device_locked, eeprom_preserve})
      rd_chk(8'h40, 32'h0000_0000, 2'b10);
      load(8'h4F, 8'h03, 8'hCD, 8'h00, 8'h00, 8'h10, 8'h00);
      do_reset(1'b0);
      `CHECK("delay", 1'b1, wait_n < 30)
      chk_bod(3'h5, 1'b1, 2'h1, 2'h2, 1'b1);
      chk_osc(1'b0, 2'h3, 1'b0, 8'h00, 4'h0);
      chk_sys(2'h3, 1'b0, 2'h3, 1'b0, 1'b0,
              3'h0, 1'b1);
      chk_sec(17'h01000, 17'h04000);
      reg_chk(17'h00FFF, FCL_BOOT);
      reg_chk(17'h01000, FCL_APP_CODE);
      reg_chk(17'h03FFF, FCL_APP_CODE);
      load(8'h13, 8'h02, 8'h80, 8'h07, 8'h00, 8'h00, 8'h5A);
      do_reset(1'b1);
      `CHECK("delay", 1'b1, wait_n >= 270)
      chk_bod(3'h0, 1'b1, 2'h0, 2'h3, 1'b0);
      chk_osc(1'b0, 2'h2, 1'b1, 8'hA5, 4'hC);
      chk_sys(2'h2, 1'b1, 2'h0, 1'b1, 1'b0, 3'h7, 1'b1);
      chk_sec(17'h04000, 17'h04000);
      reg_chk(17'h03FFF, FCL_BOOT);
      rd_chk(8'h2C, 32'h0000_0007, 2'b00);
      tally_and_finish();
   end
endmodule // tb_top
